// File: core/bss_map.svh
// Register offsets, field positions and reset values of the split status bank
`ifndef BSS_MAP_SVH
`define BSS_MAP_SVH
`define BSS_STATUS_OFS      12'h000
`define BSS_MODE_OFS        12'h004
`define BSS_MODE_RESET      1'h0
`define BSS_BIT_CAP133      17
`define BSS_BIT_DISCARD     18
`define BSS_BIT_UNEXP       19
`define BSS_BIT_OVERRUN     20
`define BSS_BIT_DELAYED     21
`define BSS_BIT_MODE        0
`endif

// File: core/bss_pkg.sv
// Types shared by the split status bank
package bss_pkg;
   typedef enum logic {
      BSS_FORWARD = 1'b0,
      BSS_REVERSE = 1'b1
   } bss_mode_t;
endpackage

// File: core/bss_flag.sv
// One sticky write-one-to-clear status flag with a mode enable
`timescale 1ns/1ps
module bss_flag (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic enable,
   input  wire logic set_pulse,
   input  wire logic clear_pulse,
   output logic      flag
);
   logic flag_reg;
   logic flag_next;

   // Set wins over clear; disabled flag forced to zero
   assign flag_next = !enable ? 1'b0 : (set_pulse ? 1'b1 : (clear_pulse ? 1'b0 : flag_reg));
   assign flag      = flag_reg;

   // Flag storage
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flag_reg <= 1'b0;
      end else begin
         flag_reg <= flag_next;
      end
   end

   AST_SET_WINS: assert property (@(posedge pclk) disable iff (!presetn)
      enable && set_pulse |=> flag) else $error("flag not set after event");
   AST_DISABLED_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
      !enable |=> !flag) else $error("disabled flag not zero");
   AST_HOLDS: assert property (@(posedge pclk) disable iff (!presetn)
      enable && !set_pulse && !clear_pulse && $past(enable) |=> flag == $past(flag))
      else $error("flag changed without cause");
endmodule

// File: core/bss_split_status.sv
// Split transaction status bits of a bridge status register, reached over APB
//
// Overview of operation
// - Read-only 133MHz flag; zero forward, one reverse
// - Discard flag zero in reverse, writable forward
// - Set discard flag when completion dropped unaccepted
// - Unexpected flag zero in forward, accessible reverse
// - Set unexpected flag on own-ID unexpected completion
// - Set overrun flag on buffer-full retry/disconnect
// - Set delayed flag when commitment limit lacks room
//
// Implementation choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "bss_map.svh"
module bss_split_status (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        evt_completion_discarded,
   input  wire logic        evt_unexpected_own_id,
   input  wire logic        evt_completion_overrun,
   input  wire logic        evt_request_delayed,
   output logic             reverse_mode
);
   bss_pkg::bss_mode_t mode_reg;
   logic [31:0]        prdata_reg;
   logic [31:0]        rd_value;
   logic [3:0]         flags;
   logic [3:0]         set_vec;
   logic [3:0]         en_vec;
   logic [3:0]         clr_vec;
   logic               cap133;
   logic               is_reverse;

   // APB decode; single-cycle answers
   wire access   = psel && penable;
   wire wr_fire  = access && pwrite;
   wire hit_stat = (paddr == `BSS_STATUS_OFS);
   wire hit_mode = (paddr == `BSS_MODE_OFS);
   wire unmapped = !(hit_stat || hit_mode);
   assign pready  = 1'b1;
   assign pslverr = access && unmapped;
   assign prdata  = prdata_reg;

   // Mode view and capability flag
   assign is_reverse   = (mode_reg == bss_pkg::BSS_REVERSE);
   assign reverse_mode = is_reverse;
   assign cap133       = is_reverse;

   // Per-flag enables, events and write-one clears
   assign en_vec  = {1'b1, 1'b1, is_reverse, !is_reverse};
   assign set_vec = {evt_request_delayed, evt_completion_overrun,
                     evt_unexpected_own_id, evt_completion_discarded};
   assign clr_vec = (wr_fire && hit_stat) ? pwdata[`BSS_BIT_DELAYED:`BSS_BIT_DISCARD] : 4'h0;

   // Four sticky flags, bits 18 to 21
   for (genvar i = 0; i < 4; i++) begin : g_flag
      bss_flag u_flag (
         .pclk        (pclk),
         .presetn     (presetn),
         .enable      (en_vec[i]),
         .set_pulse   (set_vec[i]),
         .clear_pulse (clr_vec[i]),
         .flag        (flags[i])
      );
   end

   // Read mux; other bits read zero
   assign rd_value = hit_stat ? {10'h000, flags, cap133, 17'h00000} :
                     hit_mode ? {31'h00000000, is_reverse} : 32'h00000000;

   // Mode register and read data
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_reg   <= bss_pkg::bss_mode_t'(`BSS_MODE_RESET);
         prdata_reg <= 32'h00000000;
      end else begin
         if (wr_fire && hit_mode) begin
            mode_reg <= bss_pkg::bss_mode_t'(pwdata[`BSS_BIT_MODE]);
         end
         if (psel && !penable && !pwrite) begin
            prdata_reg <= rd_value;
         end
      end
   end

   // Mode, and with it the 133MHz flag, changes only through a mode write
   AST_CAP_MODE: assert property (@(posedge pclk) disable iff (!presetn)
      $changed(is_reverse) |-> $past(wr_fire && hit_mode)) else $error("133MHz flag moved without a mode write");
   AST_DISCARD_REV: assert property (@(posedge pclk) disable iff (!presetn)
      is_reverse && $past(is_reverse) |-> !flags[0]) else $error("discard flag set in reverse");
   AST_DISCARD_SET: assert property (@(posedge pclk) disable iff (!presetn)
      !is_reverse && evt_completion_discarded ##1 !is_reverse |-> flags[0])
      else $error("discard event lost");
   AST_UNEXP_FWD: assert property (@(posedge pclk) disable iff (!presetn)
      !is_reverse && $past(!is_reverse) |-> !flags[1]) else $error("unexpected flag set in forward");
   AST_UNEXP_SET: assert property (@(posedge pclk) disable iff (!presetn)
      is_reverse && evt_unexpected_own_id ##1 is_reverse |-> flags[1])
      else $error("unexpected completion lost");
   AST_OVERRUN_SET: assert property (@(posedge pclk) disable iff (!presetn)
      evt_completion_overrun |=> flags[2]) else $error("overrun event lost");
   AST_DELAY_SET: assert property (@(posedge pclk) disable iff (!presetn)
      evt_request_delayed |=> flags[3]) else $error("delayed event lost");
   AST_W1C: assert property (@(posedge pclk) disable iff (!presetn)
      wr_fire && hit_stat && pwdata[`BSS_BIT_OVERRUN] && !evt_completion_overrun |=> !flags[2])
      else $error("write one did not clear");

   // Named steps of one APB transfer
   sequence s_read_setup;
      psel && !penable && !pwrite;
   endsequence

   sequence s_status_read;
      s_read_setup ##0 hit_stat;
   endsequence

   sequence s_mode_read;
      s_read_setup ##0 hit_mode;
   endsequence

   sequence s_access_phase;
      psel && penable;
   endsequence

   sequence s_status_write;
      wr_fire && hit_stat;
   endsequence

   sequence s_mode_write;
      wr_fire && hit_mode;
   endsequence

   // Status read returns the flags latched at setup
   AST_STATUS_FLAGS: assert property (@(posedge pclk) disable iff (!presetn)
      s_status_read ##1 s_access_phase |-> prdata[`BSS_BIT_DELAYED:`BSS_BIT_DISCARD] == $past(flags))
      else $error("status read lost a flag");

   // Status read shows the capability of the mode at setup
   AST_STATUS_CAP: assert property (@(posedge pclk) disable iff (!presetn)
      s_status_read ##1 s_access_phase |-> prdata[`BSS_BIT_CAP133] == $past(is_reverse))
      else $error("status read shows wrong 133MHz flag");

   // Bits outside the block read zero
   AST_STATUS_RSVD: assert property (@(posedge pclk) disable iff (!presetn)
      s_status_read ##1 s_access_phase |-> prdata[31:22] == 10'h000 && prdata[16:0] == 17'h00000)
      else $error("status read shows foreign bits");

   // Mode read returns the mode bit alone
   AST_MODE_READ: assert property (@(posedge pclk) disable iff (!presetn)
      s_mode_read ##1 s_access_phase |-> prdata == {31'h00000000, $past(is_reverse)})
      else $error("mode read wrong");

   // Mode write lands at the access edge
   AST_MODE_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
      s_mode_write |=> is_reverse == $past(pwdata[`BSS_BIT_MODE]))
      else $error("mode write did not land");

   // Unmapped access errors and leaves the mode alone
   AST_UNMAPPED_ERR: assert property (@(posedge pclk) disable iff (!presetn)
      s_access_phase ##0 unmapped |-> pslverr ##1 $stable(is_reverse))
      else $error("unmapped access mishandled");

   // Mapped access never errors
   AST_MAPPED_OK: assert property (@(posedge pclk) disable iff (!presetn)
      s_access_phase ##0 !unmapped |-> !pslverr)
      else $error("mapped access errored");

   // Writing zero keeps a set flag
   AST_W0_KEEP_OVR: assert property (@(posedge pclk) disable iff (!presetn)
      s_status_write ##0 (flags[2] && !pwdata[`BSS_BIT_OVERRUN]) |=> flags[2])
      else $error("zero write cleared overrun flag");

   AST_W0_KEEP_DLY: assert property (@(posedge pclk) disable iff (!presetn)
      s_status_write ##0 (flags[3] && !pwdata[`BSS_BIT_DELAYED]) |=> flags[3])
      else $error("zero write cleared delayed flag");

   // Writing one clears when no event competes
   AST_W1C_DLY: assert property (@(posedge pclk) disable iff (!presetn)
      s_status_write ##0 (pwdata[`BSS_BIT_DELAYED] && !evt_request_delayed) |=> !flags[3])
      else $error("write one did not clear delayed flag");

   AST_W1C_DISCARD: assert property (@(posedge pclk) disable iff (!presetn)
      s_status_write ##0 (pwdata[`BSS_BIT_DISCARD] && !evt_completion_discarded) |=> !flags[0])
      else $error("write one did not clear discard flag");

   // Event in the same cycle as a clear wins
   AST_SET_BEATS_CLR: assert property (@(posedge pclk) disable iff (!presetn)
      s_status_write ##0 (pwdata[`BSS_BIT_OVERRUN] && evt_completion_overrun) |=> flags[2])
      else $error("clear beat a same-cycle event");

   // No flag rises without its event
   AST_NO_SPURIOUS_DIS: assert property (@(posedge pclk) disable iff (!presetn)
      !evt_completion_discarded && !flags[0] |=> !flags[0])
      else $error("discard flag rose without event");

   AST_NO_SPURIOUS_UNX: assert property (@(posedge pclk) disable iff (!presetn)
      !evt_unexpected_own_id && !flags[1] |=> !flags[1])
      else $error("unexpected flag rose without event");

   AST_NO_SPURIOUS_OVR: assert property (@(posedge pclk) disable iff (!presetn)
      !evt_completion_overrun && !flags[2] |=> !flags[2])
      else $error("overrun flag rose without event");

   AST_NO_SPURIOUS_DLY: assert property (@(posedge pclk) disable iff (!presetn)
      !evt_request_delayed && !flags[3] |=> !flags[3])
      else $error("delayed flag rose without event");

endmodule

// File: testbench/bss_evt_src.sv
// Primary bus traffic model raising split status events
`timescale 1ns/1ps
module bss_evt_src (
   input  wire logic       pclk,
   input  wire logic [3:0] fire,
   output logic      [3:0] evt
);
   initial evt = 4'h0;
   // One-cycle event pulses launched after a clock edge
   always @(posedge pclk) begin
      evt <= fire;
   end
endmodule

// File: testbench/bss_split_status_test.sv
// Self-checking bench for the split status bank
`timescale 1ns/1ps
`include "bss_map.svh"
module bss_split_status_test;
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, rd;
   logic [31:0] prdata;
   logic        pready, pslverr, reverse_mode;
   logic [3:0]  fire = 4'h0, evt;
   int          mismatches = 0, n_checks = 0;
   always #50 pclk = ~pclk;
   bss_evt_src u_src (.pclk(pclk), .fire(fire), .evt(evt));
   bss_split_status u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .evt_completion_discarded(evt[0]), .evt_unexpected_own_id(evt[1]), .evt_completion_overrun(evt[2]),
      .evt_request_delayed(evt[3]), .reverse_mode(reverse_mode));
   // Compare and count
   task automatic check(string what, logic [31:0] exp, logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   // One APB transfer, held until pready is seen high
   task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         mismatches++;
         $display("mismatch pready expected 1 seen %b", pready);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   // Read status word and compare
   task automatic rdchk(string what, logic [31:0] exp);
      apb(1'b0, `BSS_STATUS_OFS, 32'h0);
      check(what, exp, rd);
   endtask
   // Pulse the given events, let the flags settle
   task automatic pulse(logic [3:0] m);
      fire <= m;
      @(posedge pclk);
      fire <= 4'h0;
      repeat (2) @(posedge pclk);
   endtask
   task automatic t_forward;
      rdchk("status after reset", 32'h0);
      check("mode after reset", 32'h0, {31'h0, reverse_mode});
      pulse(4'hf);
      rdchk("forward events", 32'h0034_0000);
      check("unexpected held low", 32'h0, {31'h0, rd[`BSS_BIT_UNEXP]});
      apb(1'b1, `BSS_STATUS_OFS, 32'h0);
      rdchk("write zero keeps", 32'h0034_0000);
      apb(1'b1, `BSS_STATUS_OFS, 32'h0004_0000);
      rdchk("clear discard only", 32'h0030_0000);
      apb(1'b1, `BSS_STATUS_OFS, 32'hffff_ffff);
      rdchk("clear all", 32'h0);
      $display("test forward done");
   endtask
   task automatic t_reverse;
      apb(1'b1, `BSS_MODE_OFS, 32'h1);
      rdchk("reverse capability", 32'h0002_0000);
      pulse(4'hf);
      rdchk("reverse events", 32'h003a_0000);
      apb(1'b1, `BSS_STATUS_OFS, 32'hffff_ffff);
      rdchk("reverse clear", 32'h0002_0000);
      apb(1'b1, 12'h008, 32'hffff_ffff);
      check("unmapped error", 32'h1, {31'h0, err});
      $display("test reverse done");
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // Main sequence
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      t_forward();
      t_reverse();
      end_of_test();
   end
   // Watchdog
   initial begin
      repeat (3000) @(posedge pclk);
      mismatches++;
      end_of_test();
   end
endmodule
